// ### rsc_checker.sv
// assertions on the link wires between the two ends
`timescale 1ns/10ps
module rsc_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce,
  input wire logic sck,
  input wire logic sdi_oe,
  input wire logic serial_data_out,
  input wire logic sdo_oe,
  input wire logic single_wire,
  input wire logic dev_din
);
  logic sck_r;
  logic [7:0] bit_cnt_r;
  logic [7:0] cmd_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // -------------------------------------------------
  // link bit count and command capture
  // -------------------------------------------------
  // sck comes from a clk_i register, so an edge detect is exact
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_r <= 1'b0;
    end else begin
      sck_r <= sck;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_r <= 8'h00;
    end else if (!ce) begin
      bit_cnt_r <= 8'h00;
    end else if (sck && !sck_r) begin
      bit_cnt_r <= bit_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_r <= 8'h00;
    end else if (ce && sck && !sck_r && bit_cnt_r < 8'h08) begin
      cmd_r <= {cmd_r[6:0], dev_din};
    end
  end

  // -------------------------------------------------
  // properties
  // -------------------------------------------------
  a_ce_low_quiet: assert property (!ce |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_idle_sck_low: assert property (!ce |-> !sck)
    else $error("serial clock high while idle");
  a_sdo_on_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(serial_data_out) |-> $fell(sck))
    else $error("data out moved off a falling edge");
  a_single_release: assert property (single_wire && sdo_oe |-> !sdi_oe)
    else $error("both ends drive the shared line");
  a_cmd_phase: assert property (ce && bit_cnt_r < 8'h08 |-> sdi_oe && !sdo_oe)
    else $error("wrong driver during command byte");
  a_write_quiet: assert property (ce && bit_cnt_r >= 8'h08 && !cmd_r[7] |-> !sdo_oe)
    else $error("data out driven in a write");
  a_read_start: assert property (ce && bit_cnt_r == 8'h08 && cmd_r[7] && $fell(sck) |-> sdo_oe)
    else $error("read data late after command");
  a_ce_setup: assert property ($rose(ce) |-> !sck [*3])
    else $error("clock started too soon after select");
  a_whole_bytes: assert property ($fell(ce) |-> bit_cnt_r[2:0] == 3'h0)
    else $error("transfer ended inside a byte");
endmodule

// ### rsc_dev.sv
// rtc device end: serial slave with transfer cache and write-back
// Function
// - chip enable low holds serial logic reset
// - sample data input on rising clock
// - drive output on falling edge, else released
// - master raises chip enable to start
// - snapshot live registers into cache at start
// - cache stays frozen during whole transfer
// - write back only modified registers at end
// - bytes of eight bits, msb first
// - first byte is the command
// - one bit per serial clock pulse
// - master keeps serial clock low idle
// - index advances after every byte
// - page fixed until chip enable drops
// - master drops chip enable to end
// - command bit 7 selects read or write
// - bits 6..3 page, top page bit zero
// - bits 2..0 give start index
// - output released for whole write transfer
// - chip enable never held high forever
// - master always drives separate data input; host drops sdi_oe during read data even when single_wire is low
// - single wire: master releases during reads
`timescale 1ns/10ps
module rsc_dev
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  rsc_if.dev link,
  input wire logic upd_we_i,
  input wire logic [rsc_pkg::REG_AW-1:0] upd_addr_i,
  input wire logic [rsc_pkg::BYTE_W-1:0] upd_data_i,
  input wire logic [rsc_pkg::REG_AW-1:0] mon_addr_i,
  output logic [rsc_pkg::BYTE_W-1:0] mon_data_o,
  output logic busy_o,
  output logic wb_pulse_o
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // link domain: serial clock, reset while chip enable is low
  // ---------------------------------------------------------------
  logic link_rst_n;
  logic [2:0] bit_cnt_r;
  logic [BYTE_W-2:0] shin_r;
  logic cmd_done_r;
  logic rw_r;
  logic [IDX_W-1:0] idx_r;
  logic [BYTE_W-1:0] byte_nxt;
  logic byte_end;
  logic sdo_r;
  logic sdo_oe_r;
  logic [BYTE_W-1:0] rd_byte;

  // survives chip enable low so that the write-back can read it
  logic [PAGE_FULL_W-1:0] page_r;
  logic [BYTE_W-1:0] wbuf_r [0:(1<<IDX_W)-1];
  logic [(1<<IDX_W)-1:0] dirty_r;
  logic xfer_tog_r;

  // clock domain: live registers and the transfer cache
  logic [BYTE_W-1:0] live_r [0:REG_DEPTH-1];
  logic [BYTE_W-1:0] cache_r [0:REG_DEPTH-1];

  assign link_rst_n = link.ce & arst_n_i;
  assign byte_nxt = {shin_r, link.dev_din};
  assign byte_end = (bit_cnt_r == BIT_LAST);
  assign rd_byte = cache_r[{page_r[PAGE_W-1:0], idx_r}];

  // ---------------------------------------------------------------
  // receive side, rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= '0;
      shin_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shin_r <= byte_nxt[BYTE_W-2:0];
    end
  end

  always_ff @(posedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cmd_done_r <= 1'b0;
      rw_r <= CMD_WRITE;
      idx_r <= '0;
    end else if (byte_end) begin
      if (!cmd_done_r) begin
        cmd_done_r <= 1'b1;
        rw_r <= byte_nxt[CMD_RW_BIT];
        idx_r <= byte_nxt[CMD_IDX_MSB:0];
      end else begin
        // plain add of three bits rolls 7 over to 0 in the same page
        idx_r <= idx_r + IDX_STEP;
      end
    end
  end

  // page and write buffer carry over the chip enable drop
  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_r <= '0;
      xfer_tog_r <= 1'b0;
    end else if (byte_end && !cmd_done_r) begin
      page_r <= rsc_page_of(byte_nxt);
      xfer_tog_r <= ~xfer_tog_r;
    end
  end

  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dirty_r <= '0;
    end else if (byte_end && !cmd_done_r) begin
      dirty_r <= '0;
    end else if (byte_end && rw_r == CMD_WRITE) begin
      dirty_r[idx_r] <= 1'b1;
    end
  end

  always_ff @(posedge link.sck) begin
    if (byte_end && cmd_done_r && rw_r == CMD_WRITE) begin
      wbuf_r[idx_r] <= byte_nxt;
    end
  end

  // ---------------------------------------------------------------
  // transmit side, falling edge
  // ---------------------------------------------------------------
  // bit_cnt_r already points at the next bit, so ~bit_cnt_r is 7 - n
  always_ff @(negedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (cmd_done_r && rw_r == CMD_READ) begin
      sdo_oe_r <= 1'b1;
      sdo_r <= rd_byte[~bit_cnt_r];
    end else begin
      sdo_oe_r <= 1'b0;
    end
  end

  assign link.serial_data_out = sdo_r;
  assign link.sdo_oe = sdo_oe_r;

  // ---------------------------------------------------------------
  // crossing into the system clock
  // ---------------------------------------------------------------
  logic ce_s;
  logic tog_s;
  logic [1:0] sync_q;
  logic ce_d_r;
  logic tog_seen_r;
  logic ce_rise;
  logic ce_fall;

  rsc_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({link.ce, xfer_tog_r}),
    .q_o(sync_q)
  );

  assign ce_s = sync_q[1];
  assign tog_s = sync_q[0];

  assign ce_rise = ce_s && !ce_d_r;
  assign ce_fall = !ce_s && ce_d_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ce_d_r <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      ce_d_r <= ce_s;
      busy_o <= ce_s;
    end
  end

  // a transfer that never completed its command has nothing to write back
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tog_seen_r <= 1'b0;
      wb_pulse_o <= 1'b0;
    end else begin
      wb_pulse_o <= 1'b0;
      if (ce_fall && tog_s != tog_seen_r) begin
        tog_seen_r <= tog_s;
        wb_pulse_o <= |dirty_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // cache snapshot and live registers
  // ---------------------------------------------------------------
  // the first serial edge comes well after the two-flop delay of ce_rise,
  // so the cache is settled before the link reads it
  always_ff @(posedge clk_i) begin
    if (ce_rise) begin
      cache_r <= live_r;
    end
  end

  // write-back wins over a timekeeping update in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        live_r[i] <= LIVE_RST;
      end
    end else begin
      if (upd_we_i) begin
        live_r[upd_addr_i] <= upd_data_i;
      end
      if (ce_fall && tog_s != tog_seen_r) begin
        for (int j = 0; j < (1 << IDX_W); j++) begin
          if (dirty_r[j]) begin
            live_r[{page_r[PAGE_W-1:0], IDX_W'(j)}] <= wbuf_r[j];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mon_data_o <= LIVE_RST;
    end else begin
      mon_data_o <= live_r[mon_addr_i];
    end
  end
endmodule

// ### rsc_host.sv
// serial master end: makes chip enable and the serial clock from clk_i
`timescale 1ns/10ps
module rsc_host
  import rsc_pkg::*;
#(
  parameter int HALF = rsc_pkg::HALF_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  rsc_if.host link,
  input wire logic start_i,
  input wire logic rw_i,
  input wire logic [rsc_pkg::PAGE_W-1:0] page_i,
  input wire logic [rsc_pkg::IDX_W-1:0] idx_i,
  input wire logic [3:0] nbytes_i,
  input wire logic [rsc_pkg::BYTE_W-1:0] wdata_i,
  output logic wr_take_o,
  output logic [rsc_pkg::BYTE_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic done_o
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF - 1);
  rsc_hstate_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] bit_r;
  logic [3:0] left_r;
  logic rw_r;
  logic is_cmd_r;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] rx_r;
  logic sck_r;
  logic ce_r;
  logic din_s;
  logic tick;

  // half period must exceed the sync delay so the sample is settled
  rsc_sync #(.W(1)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(link.host_din),
    .q_o(din_s)
  );

  assign tick = (cnt_r == HALF_LAST);
  assign link.ce = ce_r;
  assign link.sck = sck_r;
  assign link.serial_data_in = tx_r[BYTE_W-1];
  // released while deselected and while the device returns read data
  assign link.sdi_oe = ce_r && !(rw_r == CMD_READ && !is_cmd_r);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      left_r <= '0;
      rw_r <= CMD_WRITE;
      is_cmd_r <= 1'b1;
      tx_r <= '0;
      rx_r <= '0;
      sck_r <= 1'b0;
      ce_r <= 1'b0;
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      cnt_r <= tick ? '0 : cnt_r + 8'h01;
      case (state_r)
        H_IDLE: begin
          cnt_r <= '0;
          if (start_i) begin
            state_r <= H_SETUP;
            ce_r <= 1'b1;
            busy_o <= 1'b1;
            rw_r <= rw_i;
            is_cmd_r <= 1'b1;
            left_r <= nbytes_i;
            bit_r <= '0;
            tx_r <= rsc_cmd(rw_i, page_i, idx_i);
          end
        end
        H_SETUP: begin
          if (tick) begin
            state_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            sck_r <= ~sck_r;
            if (!sck_r) begin
              rx_r <= {rx_r[BYTE_W-2:0], din_s};
            end else begin
              bit_r <= bit_r + 3'h1;
              tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
              if (bit_r == BIT_LAST) begin
                is_cmd_r <= 1'b0;
                if (!is_cmd_r && rw_r == CMD_READ) begin
                  rd_data_o <= rx_r;
                  rd_valid_o <= 1'b1;
                end
                if (!is_cmd_r) begin
                  left_r <= left_r - 4'h1;
                end
                if ((is_cmd_r && left_r == 4'h0) || (!is_cmd_r && left_r == 4'h1)) begin
                  state_r <= H_END;
                end else if (rw_r == CMD_WRITE) begin
                  tx_r <= wdata_i;
                  wr_take_o <= 1'b1;
                end else begin
                  tx_r <= READ_FILL;
                end
              end
            end
          end
        end
        H_END: begin
          if (tick) begin
            state_r <= H_IDLE;
            ce_r <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rsc_if.sv
// link wires between the serial master end and the rtc device end
`timescale 1ns/10ps
interface rsc_if;
  logic ce;
  logic sck;
  logic serial_data_in;
  logic sdi_oe;
  logic serial_data_out;
  logic sdo_oe;
  // set by the bench: data in and data out tied into one line
  logic single_wire;
  logic dio_line;
  logic dev_din;
  logic host_din;

  // released line reads high, as with a weak pull-up
  assign dio_line = sdi_oe ? serial_data_in : (sdo_oe ? serial_data_out : 1'b1);
  assign dev_din = single_wire ? dio_line : serial_data_in;
  assign host_din = single_wire ? dio_line : (sdo_oe ? serial_data_out : 1'b1);

  modport dev (
    input ce,
    input sck,
    input dev_din,
    output serial_data_out,
    output sdo_oe
  );

  modport host (
    output ce,
    output sck,
    output serial_data_in,
    output sdi_oe,
    input host_din
  );
endinterface

// ### rsc_pkg.sv
// shared constants, types and command helpers for the cached rtc serial port
package rsc_pkg;

  // ---------------------------------------------------------------
  // byte, command and register geometry
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int IDX_W = 3;
  localparam int PAGE_W = 4;
  localparam int PAGE_FULL_W = 5;
  localparam int REG_AW = PAGE_W + IDX_W;
  localparam int REG_DEPTH = 1 << REG_AW;
  localparam int CMD_RW_BIT = 7;
  localparam int CMD_PAGE_MSB = 6;
  localparam int CMD_PAGE_LSB = 3;
  localparam int CMD_IDX_MSB = 2;
  localparam logic CMD_WRITE = 1'b0;
  localparam logic CMD_READ = 1'b1;
  localparam logic PAGE_TOP_BIT = 1'b0;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [BYTE_W-1:0] LIVE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] READ_FILL = 8'hFF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;
  localparam int HALF_DEF = 4;
  localparam int CNT_W = 8;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_SHIFT = 4'b0100,
    H_END   = 4'b1000
  } rsc_hstate_t;

  // ---------------------------------------------------------------
  // command byte helpers
  // ---------------------------------------------------------------
  function automatic logic [BYTE_W-1:0] rsc_cmd(input logic rw,
                                                input logic [PAGE_W-1:0] page,
                                                input logic [IDX_W-1:0] idx);
    rsc_cmd = {rw, page, idx};
  endfunction

  function automatic logic [PAGE_FULL_W-1:0] rsc_page_of(input logic [BYTE_W-1:0] cmd);
    rsc_page_of = {PAGE_TOP_BIT, cmd[CMD_PAGE_MSB:CMD_PAGE_LSB]};
  endfunction

endpackage

// ### rsc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module rsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ### rtc_spi_slave_cached_access_test.sv
// self-checking bench for the two serial ends joined on one link
`timescale 1ns/10ps
module rtc_spi_slave_cached_access_test;
  import rsc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b1;
  logic start_i = 1'b0;
  logic rw_i = 1'b0;
  logic [3:0] page_i = 4'h0;
  logic [2:0] idx_i = 3'h0;
  logic [3:0] nbytes_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_take_o, rd_valid_o, h_busy_o, done_o, d_busy_o, wb_pulse_o;
  logic [7:0] rd_data_o, mon_data_o;
  logic upd_we_i = 1'b0;
  logic [6:0] upd_addr_i = 7'h00;
  logic [7:0] upd_data_i = 8'h00;
  logic [6:0] mon_addr_i = 7'h00;
  logic [7:0] wq [0:3];
  logic [7:0] rq [$];
  logic [7:0] wb_cnt = 8'h00;
  int err_count = 0;
  int n_tests = 0;

  rsc_if bus ();
  initial bus.single_wire = 1'b0;

  rsc_host u_rsc_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(bus), .start_i(start_i),
    .rw_i(rw_i), .page_i(page_i), .idx_i(idx_i), .nbytes_i(nbytes_i), .wdata_i(wdata_i),
    .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .busy_o(h_busy_o), .done_o(done_o));
  rsc_dev u_rsc_dev (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(bus), .upd_we_i(upd_we_i),
    .upd_addr_i(upd_addr_i), .upd_data_i(upd_data_i), .mon_addr_i(mon_addr_i),
    .mon_data_o(mon_data_o), .busy_o(d_busy_o), .wb_pulse_o(wb_pulse_o));
  rsc_checker u_rsc_checker (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce(bus.ce),
    .sck(bus.sck), .sdi_oe(bus.sdi_oe), .serial_data_out(bus.serial_data_out), .sdo_oe(bus.sdo_oe),
    .single_wire(bus.single_wire), .dev_din(bus.dev_din));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (wb_pulse_o === 1'b1) wb_cnt <= wb_cnt + 8'h01;

  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one transfer; a nonzero ud makes a timekeeping write mid-transfer
  task automatic xfer(input logic rw, input logic [3:0] pg, input logic [2:0] ix,
                      input logic [3:0] n, input logic [6:0] ua, input logic [7:0] ud);
    int k;
    int c;
    k = 0;
    rq.delete();
    rw_i = rw;
    page_i = pg;
    idx_i = ix;
    nbytes_i = n;
    wdata_i = wq[0];
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    for (c = 0; c < 2000 && done_o !== 1'b1; c++) begin
      @(posedge clk_i);
      #1;
      upd_we_i = (c == 60) && (ud != 8'h00);
      upd_addr_i = ua;
      upd_data_i = ud;
      if (c == 60) chk({6'h00, h_busy_o, d_busy_o}, 8'h03);
      if (wr_take_o === 1'b1) begin
        k++;
        wdata_i = wq[k];
      end
      if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    end
    chk({7'h00, done_o}, 8'h01);
    upd_we_i = 1'b0;
    // room for write-back and the idle gap before the next select
    repeat (8) @(posedge clk_i);
    #1;
    chk({6'h00, h_busy_o, d_busy_o}, 8'h00);
  endtask

  task automatic mon(input logic [6:0] a, input logic [7:0] e);
    mon_addr_i = a;
    repeat (2) @(posedge clk_i);
    #1;
    chk(mon_data_o, e);
  endtask

  task automatic poke(input logic [6:0] a, input logic [7:0] d);
    upd_we_i = 1'b1;
    upd_addr_i = a;
    upd_data_i = d;
    @(posedge clk_i);
    #1;
    upd_we_i = 1'b0;
    // one idle edge so a following poke does not re-raise the strobe at once
    @(posedge clk_i);
    #1;
  endtask

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_write_wrap();
    logic [7:0] b;
    b = wb_cnt;
    wq[0] = 8'h45;
    wq[1] = 8'h10;
    wq[2] = 8'hA5;
    xfer(CMD_WRITE, 4'h1, 3'h6, 4'h3, 7'h09, 8'h3C);
    chk(wb_cnt, b + 8'h01);
    mon(7'h0E, 8'h45);
    mon(7'h0F, 8'h10);
    mon(7'h08, 8'hA5);
    mon(7'h09, 8'h3C);
  endtask

  task automatic t_read_frozen();
    logic [7:0] b;
    b = wb_cnt;
    bus.single_wire = 1'b1;
    xfer(CMD_READ, 4'h1, 3'h6, 4'h3, 7'h0F, 8'h99);
    bus.single_wire = 1'b0;
    chk(8'(rq.size()), 8'h03);
    chk(rq[0], 8'h45);
    chk(rq[1], 8'h10);
    chk(rq[2], 8'hA5);
    chk(wb_cnt, b);
    mon(7'h0F, 8'h99);
  endtask

  task automatic t_read_split();
    poke(7'h07, 8'hC3);
    poke(7'h00, 8'h5E);
    xfer(CMD_READ, 4'h0, 3'h7, 4'h2, 7'h00, 8'h00);
    chk(rq[0], 8'hC3);
    chk(rq[1], 8'h5E);
  endtask

  task automatic t_page_top();
    logic [7:0] b;
    wq[0] = 8'h81;
    xfer(CMD_WRITE, 4'hF, 3'h7, 4'h1, 7'h00, 8'h00);
    mon(7'h7F, 8'h81);
    b = wb_cnt;
    xfer(CMD_WRITE, 4'h2, 3'h0, 4'h0, 7'h00, 8'h00);
    chk(wb_cnt, b);
    mon(7'h10, 8'h00);
  endtask

  // a real falling edge, so the link-side flops that only see arst_n_i reset
  initial begin
    #1;
    arst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    t_write_wrap();
    t_read_frozen();
    t_read_split();
    t_page_top();
    give_verdict();
  end

  // five transfers of some 300 cycles each fit well inside this span
  initial begin
    #100000;
    err_count++;
    $display("unexpected at %0t: got %h expected %h", $time, 8'h00, 8'h01);
    give_verdict();
  end
endmodule
